// >>> hw/tss_sequencer.v
// Purpose: Debug trigger state sequencer with three match channels and final state
// Assumes: Match and tag-hit inputs come from logic on clk_sys; register port on clk_sys
// Notes: Transition tables for the 4-bit state controls are given by functions below
`timescale 1ns/1ps
`include "tss_map.vh"

// Summary of operation
// - Three match inputs, three state control registers
// - Fourth control bit extends, low three unchanged except ch0 of code 1000 in State1 and State3
// - Range mode ignores channel one match
// - State1 code 0000 triggers on any match
// - State3 code 1000 returns to State2 on ch0, finals on ch2
// - Final-state transitions win simultaneous hits
// - Otherwise lowest matching channel wins
// - Extended State1 code 1000 goes to State3 on ch0
// - Range events arrive only on channel zero
// - Final state requests breakpoint, tagged at execution
// - Tag bit defers transition until opcode executes
module tss_sequencer (
	input wire clk_sys,
	input wire rst,
	input wire [2:0] match_ch,
	input wire [2:0] tag_hit,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output reg breakpoint_req,
	output reg [3:0] seq_state
);
	localparam ST_S1 = 4'h1;
	localparam ST_S2 = 4'h2;
	localparam ST_S3 = 4'h4;
	localparam ST_FINAL = 4'h8;

	reg [3:0] state1_control;
	reg [3:0] state2_control;
	reg [3:0] state3_control;
	reg [7:0] ctrl;
	reg [3:0] state;
	reg [3:0] next_state;
	reg [2:0] event_vec;
	reg [1:0] d0;
	reg [1:0] d1;
	reg [1:0] d2;
	reg [3:0] code;
	reg [1:0] fin;
	// Per-channel targets from the current state's control code
	reg [2:0] t0;
	reg [2:0] t1;
	reg [2:0] t2;

	// Disarm then arm is how software restarts a finished sequence
	wire rearm;
	assign rearm = reg_wr && (reg_addr == `TSS_OFF_CTRL) && reg_wdata[`TSS_CTRL_ARM] && !ctrl[`TSS_CTRL_ARM];

	// Per-channel target: 0 stay, 1..3 go to state n, encoded here as 2 bits plus final flag
	// Returns {final, target[1:0]}
	function [2:0] tss_target;
		input [1:0] st;
		input [3:0] c;
		input [1:0] ch;
		begin
			tss_target = 3'h0;
			case (st)
			2'd1: begin
				case (c[2:0])
				3'h0: tss_target = (c[3] && ch == 2'd0) ? {1'b0, `TSS_NXT_S3} : {1'b1, 2'h0};
				3'h1: tss_target = (ch == 2'd0) ? {1'b0, `TSS_NXT_S2} : 3'h0;
				3'h2: tss_target = (ch == 2'd1) ? {1'b0, `TSS_NXT_S2} : 3'h0;
				3'h3: tss_target = (ch == 2'd2) ? {1'b0, `TSS_NXT_S2} : 3'h0;
				3'h4: tss_target = (ch == 2'd0) ? {1'b0, `TSS_NXT_S3} : 3'h0;
				3'h5: tss_target = (ch == 2'd1) ? {1'b0, `TSS_NXT_S3} : 3'h0;
				3'h6: tss_target = (ch == 2'd2) ? {1'b0, `TSS_NXT_S3} : 3'h0;
				default: tss_target = (ch == 2'd0) ? {1'b1, 2'h0} : 3'h0;
				endcase
				if (c[3] && c[2:0] != 3'h0 && ch != 2'd0 && tss_target == 3'h0)
					tss_target = {1'b1, 2'h0};
			end
			2'd2: begin
				case (c[2:0])
				3'h0: tss_target = (ch == 2'd0) ? {1'b0, `TSS_NXT_S1} : 3'h0;
				3'h1: tss_target = (ch == 2'd1) ? {1'b0, `TSS_NXT_S1} : 3'h0;
				3'h2: tss_target = (ch == 2'd2) ? {1'b0, `TSS_NXT_S1} : 3'h0;
				3'h3: tss_target = (ch == 2'd0) ? {1'b0, `TSS_NXT_S3} : 3'h0;
				3'h4: tss_target = (ch == 2'd1) ? {1'b0, `TSS_NXT_S3} : 3'h0;
				3'h5: tss_target = (ch == 2'd2) ? {1'b0, `TSS_NXT_S3} : 3'h0;
				3'h6: tss_target = (ch == 2'd0) ? {1'b1, 2'h0} : 3'h0;
				default: tss_target = (ch == 2'd1) ? {1'b1, 2'h0} : 3'h0;
				endcase
				if (c[3] && tss_target == 3'h0)
					tss_target = (ch == 2'd2) ? {1'b1, 2'h0} : {1'b0, `TSS_NXT_S1};
			end
			2'd3: begin
				case (c[2:0])
				3'h0: tss_target = (ch == 2'd0) ? {1'b1, 2'h0} : 3'h0;
				3'h1: tss_target = (ch == 2'd1) ? {1'b1, 2'h0} : 3'h0;
				3'h2: tss_target = (ch == 2'd2) ? {1'b1, 2'h0} : 3'h0;
				3'h3: tss_target = (ch == 2'd0) ? {1'b0, `TSS_NXT_S1} : 3'h0;
				3'h4: tss_target = (ch == 2'd1) ? {1'b0, `TSS_NXT_S1} : 3'h0;
				3'h5: tss_target = (ch == 2'd2) ? {1'b0, `TSS_NXT_S1} : 3'h0;
				3'h6: tss_target = (ch != 2'd0) ? {1'b1, 2'h0} : 3'h0;
				default: tss_target = (ch == 2'd1) ? {1'b0, `TSS_NXT_S1} : 3'h0;
				endcase
				if (c[3] && c[2:0] == 3'h0)
					tss_target = (ch == 2'd0) ? {1'b0, `TSS_NXT_S2} : ((ch == 2'd2) ? {1'b1, 2'h0} : 3'h0);
			end
			default: tss_target = 3'h0;
			endcase
		end
	endfunction

	// Unknown targets fall back to State1 rather than a code that is not one-hot
	function [3:0] tss_onehot;
		input [1:0] t;
		begin
			case (t)
			`TSS_NXT_S1: tss_onehot = ST_S1;
			`TSS_NXT_S2: tss_onehot = ST_S2;
			`TSS_NXT_S3: tss_onehot = ST_S3;
			default: tss_onehot = ST_S1;
			endcase
		end
	endfunction

	// Each channel's event is its deferred tag hit when its tag bit is set, else its immediate match; range mode forces channel one's event to zero
	always @* begin
		event_vec[0] = ctrl[`TSS_CTRL_TAG0] ? tag_hit[0] : match_ch[0];
		event_vec[1] = (ctrl[`TSS_CTRL_TAG1] ? tag_hit[1] : match_ch[1]) & ~ctrl[`TSS_CTRL_RANGE];
		event_vec[2] = ctrl[`TSS_CTRL_TAG2] ? tag_hit[2] : match_ch[2];
	end

	always @* begin
		next_state = state;
		code = `TSS_SCR_RESET;
		fin = 2'h0;
		case (state)
		ST_S1: begin
			code = state1_control;
			fin = 2'd1;
		end
		ST_S2: begin
			code = state2_control;
			fin = 2'd2;
		end
		ST_S3: begin
			code = state3_control;
			fin = 2'd3;
		end
		// Final ignores every event until a rearm or a reset
		ST_FINAL: fin = 2'd0;
		default: next_state = ST_S1;
		endcase
		// Each channel's target is worked out once and shared by the priority chain
		t0 = tss_target(fin, code, 2'd0);
		t1 = tss_target(fin, code, 2'd1);
		t2 = tss_target(fin, code, 2'd2);
		d0 = t0[1:0];
		d1 = t1[1:0];
		d2 = t2[1:0];
		if (ctrl[`TSS_CTRL_ARM] && fin != 2'd0) begin
			// Final-state targets first, then lowest channel
			if ((event_vec[0] && t0 == 3'h4) ||
				(event_vec[1] && t1 == 3'h4) ||
				(event_vec[2] && t2 == 3'h4)) begin
				next_state = ST_FINAL;
			end else if (event_vec[0] && t0 != 3'h0) begin
				next_state = tss_onehot(d0);
			end else if (event_vec[1] && t1 != 3'h0) begin
				next_state = tss_onehot(d1);
			end else if (event_vec[2] && t2 != 3'h0) begin
				next_state = tss_onehot(d2);
			end
		end
		// Rearm beats a same-cycle event, so state, seq_state and the request stay in step
		if (rearm)
			next_state = ST_S1;
	end

	// Outputs are flop copies of the state so the pins never glitch on decode
	always @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_S1;
			state1_control <= `TSS_SCR_RESET;
			state2_control <= `TSS_SCR_RESET;
			state3_control <= `TSS_SCR_RESET;
			ctrl <= `TSS_CTRL_RESET;
			reg_rdata <= 8'h00;
			breakpoint_req <= 1'b0;
			seq_state <= ST_S1;
		end else begin
			// Rearm is already folded into next_state
			state <= next_state;
			seq_state <= next_state;
			// One-cycle request on entering the final state; tagged entry already waited for execution
			breakpoint_req <= (next_state == ST_FINAL) && (state != ST_FINAL);
			if (reg_wr) begin
				case (reg_addr)
				`TSS_OFF_STATE1: state1_control <= reg_wdata[3:0];
				`TSS_OFF_STATE2: state2_control <= reg_wdata[3:0];
				`TSS_OFF_STATE3: state3_control <= reg_wdata[3:0];
				`TSS_OFF_CTRL: ctrl <= {3'h0, reg_wdata[4:0]};
				default: ;
				endcase
			end
			// Reads return zero outside the cycle after a read strobe
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
				`TSS_OFF_STATE1: reg_rdata <= {4'h0, state1_control};
				`TSS_OFF_STATE2: reg_rdata <= {4'h0, state2_control};
				`TSS_OFF_STATE3: reg_rdata <= {4'h0, state3_control};
				`TSS_OFF_CTRL: reg_rdata <= ctrl;
				`TSS_OFF_STATUS: reg_rdata <= {4'h0, state};
				default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule // tss_sequencer

// >>> hw/tss_map.vh
// Purpose: Constants for the trigger state sequencer
// Assumes: Included by tss_sequencer.v only
// Notes: Register offsets are word indices on the plain register port
`ifndef TSS_MAP_VH
`define TSS_MAP_VH
`define TSS_ADDR_W 4
`define TSS_OFF_STATE1 4'h0
`define TSS_OFF_STATE2 4'h1
`define TSS_OFF_STATE3 4'h2
`define TSS_OFF_CTRL 4'h3
`define TSS_OFF_STATUS 4'h4
`define TSS_SCR_RESET 4'h0
`define TSS_CTRL_RESET 8'h00
`define TSS_CTRL_ARM 0
`define TSS_CTRL_RANGE 1
`define TSS_CTRL_TAG0 2
`define TSS_CTRL_TAG1 3
`define TSS_CTRL_TAG2 4
`define TSS_NXT_STAY 2'h0
`define TSS_NXT_S1 2'h1
`define TSS_NXT_S2 2'h2
`define TSS_NXT_S3 2'h3
`endif

// >>> verification/tss_seq_sva.sv
// Purpose: Port checker for the trigger state sequencer
// Assumes: One clock, synchronous reset
// Notes: Sees ports only, so code-dependent moves are left to the bench
`timescale 1ns/1ps
module tss_seq_sva (
	input wire clk_sys,
	input wire rst,
	input wire [2:0] match_ch,
	input wire [2:0] tag_hit,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire breakpoint_req,
	input wire [3:0] seq_state
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_state_onehot: assert property ($onehot(seq_state)) else $error("state not one-hot");
	a_reset_state1: assert property (disable iff (1'b0) rst |=> seq_state == 4'h1) else $error("no State1");
	a_bp_entry: assert property (breakpoint_req |-> seq_state == 4'h8 && $past(seq_state) != 4'h8) else $error("bp");
	a_entry_bp: assert property (seq_state == 4'h8 && $past(seq_state) != 4'h8 |-> breakpoint_req) else $error("no bp");
	a_bp_pulse: assert property (breakpoint_req |=> !breakpoint_req) else $error("bp too long");
	a_final_holds: assert property (seq_state == 4'h8 && !reg_wr |=> seq_state == 4'h8) else $error("left final");
	a_rd_unmapped: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 8'h00) else $error("unmapped");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray rdata");
endmodule // tss_seq_sva
bind tss_sequencer tss_seq_sva u_sva (.clk_sys(clk_sys), .rst(rst), .match_ch(match_ch), .tag_hit(tag_hit),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.breakpoint_req(breakpoint_req), .seq_state(seq_state));

// >>> verification/tss_match_model.sv
// Purpose: Comparator and instruction queue stand-in
// Assumes: req is held by the bench for one cycle per event
// Notes: Every match also tags; the hit lands one cycle later, at execution
`timescale 1ns/1ps
module tss_match_model (
	input wire clk_sys,
	input wire rst,
	input wire [2:0] req,
	output reg [2:0] match_ch = 3'h0,
	output reg [2:0] tag_hit = 3'h0
);
	always @(posedge clk_sys) begin
		match_ch <= rst ? 3'h0 : req;
		tag_hit <= rst ? 3'h0 : match_ch;
	end
endmodule // tss_match_model

// >>> verification/tb_top.sv
// Purpose: Directed test of the trigger state sequencer
// Assumes: Events reach the design through the match model
// Notes: Each event gets a settle gap so late tag hits are absorbed
`timescale 1ns/1ps
module tb_top;
	reg clk_sys = 1'b0;
	reg rst = 1'b1;
	reg [2:0] req = 3'h0;
	reg [3:0] reg_addr = 4'h0;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [2:0] match_ch;
	wire [2:0] tag_hit;
	wire [7:0] reg_rdata;
	wire breakpoint_req;
	wire [3:0] seq_state;
	integer err_total = 0;
	integer cmp_count = 0;
	integer bp_seen = 0;
	integer bp_want = 0;
	integer i;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (breakpoint_req === 1'b1) bp_seen <= bp_seen + 1;
	tss_match_model u_src (.clk_sys(clk_sys), .rst(rst), .req(req), .match_ch(match_ch), .tag_hit(tag_hit));
	tss_sequencer dut (.clk_sys(clk_sys), .rst(rst), .match_ch(match_ch), .tag_hit(tag_hit), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.breakpoint_req(breakpoint_req), .seq_state(seq_state));
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk_sys) reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys) reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask
	task ev(input logic [2:0] m, input logic [3:0] e);
		@(posedge clk_sys) req <= m;
		@(posedge clk_sys) req <= 3'h0;
		repeat (4) @(posedge clk_sys);
		if (e == 4'h8) bp_want = bp_want + 1;
		#1 chk("seq_state", {4'h0, e}, {4'h0, seq_state});
	endtask
	task arm(input logic [7:0] c);
		wr(4'h3, 8'h00);
		wr(4'h3, c);
	endtask
	task final_report;
		if (err_total == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 0; i < 16; i = i + 1) rd(i[3:0], (i == 4) ? 8'h01 : 8'h00);
		ev(3'h7, 4'h1);
		for (i = 0; i < 3; i = i + 1) begin
			arm(8'h01);
			ev(3'h1 << i, 4'h8);
			rd(4'h4, 8'h08);
		end
		arm(8'h03);
		ev(3'h2, 4'h1);
		ev(3'h1, 4'h8);
		wr(4'h0, 8'h08);
		wr(4'h2, 8'h08);
		rd(4'h0, 8'h08);
		arm(8'h01);
		ev(3'h1, 4'h4);
		ev(3'h1, 4'h2);
		arm(8'h01);
		ev(3'h1, 4'h4);
		ev(3'h3, 4'h2);
		arm(8'h01);
		ev(3'h3, 4'h8);
		arm(8'h01);
		ev(3'h1, 4'h4);
		ev(3'h5, 4'h8);
		wr(4'h0, 8'h00);
		// Tagged channels must wait for the execution hit, one cycle after the match
		for (i = 0; i < 3; i = i + 1) begin
			arm(8'h01 | (8'h04 << i));
			@(posedge clk_sys) req <= 3'h1 << i;
			@(posedge clk_sys) req <= 3'h0;
			@(posedge clk_sys) #1 chk("tag_defer", 8'h01, {4'h0, seq_state});
			ev(3'h0, 4'h8);
		end
		// Reset in mid-run, taken from the Final state
		@(posedge clk_sys) rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys) #1 chk("rst_state", 8'h01, {4'h0, seq_state});
		rd(4'h3, 8'h00);
		chk("bp_count", bp_want[7:0], bp_seen[7:0]);
		final_report;
	end
	// About 210 cycles expected, so 10000 cycles means a hang
	initial begin
		#100000;
		err_total = err_total + 1;
		final_report;
	end
endmodule // tb_top
